// ==== inc/crf_consts.vh ====
// Constants for the CPU core register file: widths, selectors, flag bits, resets.
// Assumes inclusion by bare name from the rtl files; definitions only.
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH

// Storage widths
`define CRF_WORD_W 16
`define CRF_ADDR20_W 20
`define CRF_FLAG_W 11

// Bank-switched register indices (per bank, 6 words)
`define CRF_IDX_D0 3'h0
`define CRF_IDX_D1 3'h1
`define CRF_IDX_D2 3'h2
`define CRF_IDX_D3 3'h3
`define CRF_IDX_A0 3'h4
`define CRF_IDX_A1 3'h5
// Words per bank; bank one starts this far above bank zero
`define CRF_BANK_WORDS 4'h6

// Access size codes
`define CRF_SZ_BYTE 2'h0
`define CRF_SZ_WORD 2'h1
`define CRF_SZ_LONG 2'h2

// Selector codes for the banked-access port
`define CRF_SEL_D0 4'h0
`define CRF_SEL_D1 4'h1
`define CRF_SEL_D2 4'h2
`define CRF_SEL_D3 4'h3
`define CRF_SEL_A0 4'h4
`define CRF_SEL_A1 4'h5
`define CRF_SEL_D0_LO 4'h6
`define CRF_SEL_D0_HI 4'h7
`define CRF_SEL_D1_LO 4'h8
`define CRF_SEL_D1_HI 4'h9
`define CRF_SEL_PAIR_EVEN 4'ha
`define CRF_SEL_PAIR_ODD 4'hb
`define CRF_SEL_ADDR_PAIR 4'hc

// Flag word bit positions
`define CRF_FLG_BANK 4
`define CRF_FLG_STACK 7

// Reset values
`define CRF_RST_WORD 16'h0000
`define CRF_RST_ADDR20 20'h00000
`define CRF_RST_FLAG 11'h000

`endif

// ==== rtl/crf_bank_mem.v ====
// Banked storage for the data and address registers, two banks of six words.
// Assumes one clock, synchronous byte-enabled writes, three registered reads.
`timescale 1ns/1ps
`include "crf_consts.vh"

module crf_bank_mem #(
   parameter WIDTH = 16,
   parameter DEPTH = 12,
   parameter AW = 4
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Write port
   input wire wr_en_i,
   input wire [AW-1:0] wr_addr_i,
   input wire [1:0] wr_be_i,
   input wire [WIDTH-1:0] wr_data_i,
   // Read ports
   input wire [AW-1:0] rd_a_addr_i,
   input wire [AW-1:0] rd_b_addr_i,
   input wire [AW-1:0] rd_c_addr_i,
   output reg [WIDTH-1:0] rd_a_data_o,
   output reg [WIDTH-1:0] rd_b_data_o,
   output reg [WIDTH-1:0] rd_c_data_o
);

   // Register storage
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   integer i;

   // Byte-lane writes, untouched lane keeps its value
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_q[i] <= `CRF_RST_WORD;
         end
      end else if (wr_en_i) begin
         if (wr_be_i[0]) begin
            mem_q[wr_addr_i][7:0] <= wr_data_i[7:0];
         end
         if (wr_be_i[1]) begin
            mem_q[wr_addr_i][WIDTH-1:8] <= wr_data_i[WIDTH-1:8];
         end
      end
   end

   // Registered read data
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_a_data_o <= `CRF_RST_WORD;
         rd_b_data_o <= `CRF_RST_WORD;
         rd_c_data_o <= `CRF_RST_WORD;
      end else begin
         rd_a_data_o <= mem_q[rd_a_addr_i];
         rd_b_data_o <= mem_q[rd_b_addr_i];
         rd_c_data_o <= mem_q[rd_c_addr_i];
      end
   end

endmodule

// ==== rtl/crf_core_regs.v ====
// CPU core register file: banked data/address registers and dedicated registers.
// Assumes execution logic on the same clock; read data appear one cycle after select.
`timescale 1ns/1ps
`include "crf_consts.vh"

module crf_core_regs #(
   parameter WORD_W = 16,
   parameter PTR_W = 20,
   parameter FLAG_W = 11
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_n_i,
   // Banked register write
   input wire gpr_wr_en_i,
   input wire [3:0] gpr_wr_sel_i,
   input wire [2*WORD_W-1:0] gpr_wr_data_i,
   // Banked register read
   input wire [3:0] gpr_rd_sel_i,
   output reg [2*WORD_W-1:0] gpr_rd_data_o,
   // Frame base and static base
   input wire frame_base_wr_i,
   input wire static_base_wr_i,
   input wire [WORD_W-1:0] base_wr_data_i,
   output reg [WORD_W-1:0] frame_base_o,
   output reg [WORD_W-1:0] static_base_o,
   // Vector table base and next instruction pointer
   input wire vector_table_base_wr_i,
   input wire [PTR_W-1:0] vector_table_base_data_i,
   output reg [PTR_W-1:0] vector_table_base_o,
   input wire next_instr_pointer_wr_i,
   input wire [PTR_W-1:0] next_instr_pointer_data_i,
   output reg [PTR_W-1:0] next_instr_pointer_o,
   // Stack pointers
   input wire user_stack_pointer_wr_i,
   input wire interrupt_stack_pointer_wr_i,
   input wire active_sp_wr_i,
   input wire [WORD_W-1:0] sp_wr_data_i,
   output reg [WORD_W-1:0] user_stack_pointer_o,
   output reg [WORD_W-1:0] interrupt_stack_pointer_o,
   output wire [WORD_W-1:0] active_sp_o,
   // Flag word
   input wire cpu_flag_word_wr_i,
   input wire [FLAG_W-1:0] cpu_flag_word_data_i,
   output reg [FLAG_W-1:0] cpu_flag_word_o
);

   // Reset synchroniser
   reg rst_meta_q;
   reg rst_sync_q;
   wire rst_n;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // Physical index: bank one sits six words above bank zero, keeping all twelve in range
   function [3:0] phys_idx;
      input bank;
      input [2:0] idx;
      begin
         phys_idx = bank ? ({1'b0, idx} + `CRF_BANK_WORDS) : {1'b0, idx};
      end
   endfunction

   // Map selector to in-bank word index of the low half
   function [2:0] sel_idx;
      input [3:0] sel;
      begin
         case (sel)
            `CRF_SEL_D1, `CRF_SEL_D1_LO, `CRF_SEL_D1_HI: sel_idx = `CRF_IDX_D1;
            `CRF_SEL_D2: sel_idx = `CRF_IDX_D2;
            `CRF_SEL_D3: sel_idx = `CRF_IDX_D3;
            `CRF_SEL_A0, `CRF_SEL_ADDR_PAIR: sel_idx = `CRF_IDX_A0;
            `CRF_SEL_A1: sel_idx = `CRF_IDX_A1;
            `CRF_SEL_PAIR_ODD: sel_idx = `CRF_IDX_D1;
            default: sel_idx = `CRF_IDX_D0;
         endcase
      end
   endfunction

   // Upper-half partner index for the 32-bit views
   function [2:0] pair_hi_idx;
      input [3:0] sel;
      begin
         case (sel)
            `CRF_SEL_PAIR_EVEN: pair_hi_idx = `CRF_IDX_D2;
            `CRF_SEL_PAIR_ODD: pair_hi_idx = `CRF_IDX_D3;
            `CRF_SEL_ADDR_PAIR: pair_hi_idx = `CRF_IDX_A1;
            default: pair_hi_idx = `CRF_IDX_D0;
         endcase
      end
   endfunction

   // True for 32-bit paired selectors
   function is_pair;
      input [3:0] sel;
      begin
         is_pair = (sel == `CRF_SEL_PAIR_EVEN) || (sel == `CRF_SEL_PAIR_ODD) ||
                   (sel == `CRF_SEL_ADDR_PAIR);
      end
   endfunction

   // True for byte selectors of the first two data registers
   function is_byte;
      input [3:0] sel;
      begin
         is_byte = (sel >= `CRF_SEL_D0_LO) && (sel <= `CRF_SEL_D1_HI);
      end
   endfunction

   // Byte selector addresses upper byte
   function is_hi_byte;
      input [3:0] sel;
      begin
         is_hi_byte = (sel == `CRF_SEL_D0_HI) || (sel == `CRF_SEL_D1_HI);
      end
   endfunction

   wire bank = cpu_flag_word_o[`CRF_FLG_BANK];
   wire use_isp = cpu_flag_word_o[`CRF_FLG_STACK];

   // Write steering for the banked storage (32-bit writes take two cycles)
   reg wr_hi_pend_q; // Upper word of a pair write still to go
   reg [3:0] wr_hi_addr_q; // Its physical index
   reg [WORD_W-1:0] wr_hi_data_q; // Its data
   reg mem_wr_en;
   reg [3:0] mem_wr_addr;
   reg [1:0] mem_wr_be;
   reg [WORD_W-1:0] mem_wr_data;

   // Select write target, lanes and data
   always @* begin
      mem_wr_en = 1'b0;
      mem_wr_addr = 4'h0;
      mem_wr_be = 2'h3;
      mem_wr_data = gpr_wr_data_i[WORD_W-1:0];
      if (wr_hi_pend_q) begin
         // Finish the upper half of a pair write
         mem_wr_en = 1'b1;
         mem_wr_addr = wr_hi_addr_q;
         mem_wr_data = wr_hi_data_q;
      end else if (gpr_wr_en_i) begin
         mem_wr_en = 1'b1;
         mem_wr_addr = phys_idx(bank, sel_idx(gpr_wr_sel_i));
         if (is_byte(gpr_wr_sel_i)) begin
            // Single lane, other byte untouched
            mem_wr_be = is_hi_byte(gpr_wr_sel_i) ? 2'h2 : 2'h1;
            mem_wr_data = {gpr_wr_data_i[7:0], gpr_wr_data_i[7:0]};
         end
      end
   end

   // Latch upper half of a 32-bit write
   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wr_hi_pend_q <= 1'b0;
         wr_hi_addr_q <= 4'h0;
         wr_hi_data_q <= `CRF_RST_WORD;
      end else if (!wr_hi_pend_q && gpr_wr_en_i && is_pair(gpr_wr_sel_i)) begin
         wr_hi_pend_q <= 1'b1;
         wr_hi_addr_q <= phys_idx(bank, pair_hi_idx(gpr_wr_sel_i));
         wr_hi_data_q <= gpr_wr_data_i[2*WORD_W-1:WORD_W];
      end else begin
         wr_hi_pend_q <= 1'b0;
      end
   end

   // Read selection delayed to line up with registered memory data
   reg [3:0] rd_sel_q;
   wire [WORD_W-1:0] rd_lo_data;
   wire [WORD_W-1:0] rd_hi_data;

   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_sel_q <= `CRF_SEL_D0;
      end else begin
         rd_sel_q <= gpr_rd_sel_i;
      end
   end

   // Storage for both banks
   crf_bank_mem #(
      .WIDTH(WORD_W),
      .DEPTH(12),
      .AW(4)
   ) u_bank_mem (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .wr_en_i(mem_wr_en),
      .wr_addr_i(mem_wr_addr),
      .wr_be_i(mem_wr_be),
      .wr_data_i(mem_wr_data),
      .rd_a_addr_i(phys_idx(bank, sel_idx(gpr_rd_sel_i))),
      .rd_b_addr_i(phys_idx(bank, pair_hi_idx(gpr_rd_sel_i))),
      .rd_c_addr_i(4'h0),
      .rd_a_data_o(rd_lo_data),
      .rd_b_data_o(rd_hi_data),
      .rd_c_data_o()
   );

   // Shape read data to the view requested
   always @* begin
      if (is_pair(rd_sel_q)) begin
         gpr_rd_data_o = {rd_hi_data, rd_lo_data};
      end else if (is_byte(rd_sel_q)) begin
         gpr_rd_data_o = {24'h000000, is_hi_byte(rd_sel_q) ? rd_lo_data[15:8]
                                                             : rd_lo_data[7:0]};
      end else begin
         gpr_rd_data_o = {16'h0000, rd_lo_data};
      end
   end

   // Dedicated registers
   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         frame_base_o <= `CRF_RST_WORD;
         static_base_o <= `CRF_RST_WORD;
         vector_table_base_o <= `CRF_RST_ADDR20;
         next_instr_pointer_o <= `CRF_RST_ADDR20;
         cpu_flag_word_o <= `CRF_RST_FLAG;
      end else begin
         if (frame_base_wr_i) begin
            frame_base_o <= base_wr_data_i;
         end
         if (static_base_wr_i) begin
            static_base_o <= base_wr_data_i;
         end
         if (vector_table_base_wr_i) begin
            vector_table_base_o <= vector_table_base_data_i;
         end
         if (next_instr_pointer_wr_i) begin
            next_instr_pointer_o <= next_instr_pointer_data_i;
         end
         if (cpu_flag_word_wr_i) begin
            cpu_flag_word_o <= cpu_flag_word_data_i;
         end
      end
   end

   // Stack pointers; active-pointer write goes to the flagged one
   always @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         user_stack_pointer_o <= `CRF_RST_WORD;
         interrupt_stack_pointer_o <= `CRF_RST_WORD;
      end else begin
         if (user_stack_pointer_wr_i || (active_sp_wr_i && !use_isp)) begin
            user_stack_pointer_o <= sp_wr_data_i;
         end
         if (interrupt_stack_pointer_wr_i || (active_sp_wr_i && use_isp)) begin
            interrupt_stack_pointer_o <= sp_wr_data_i;
         end
      end
   end

   // Active stack pointer view
   assign active_sp_o = use_isp ? interrupt_stack_pointer_o : user_stack_pointer_o;

endmodule

// ==== testbench/crf_core_regs_monitor.sv ====
// Checker for the core register file: base registers, stack select, flag word.
// Assumes binding onto the register file top, sampling on its clock and raw reset.
`timescale 1ns/1ps
`include "crf_consts.vh"
module crf_core_regs_monitor #(
   parameter WORD_W = 16,
   parameter FLAG_W = 11
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Base registers
   input wire logic frame_base_wr_i,
   input wire logic static_base_wr_i,
   input wire logic [WORD_W-1:0] base_wr_data_i,
   input wire logic [WORD_W-1:0] frame_base_o,
   input wire logic [WORD_W-1:0] static_base_o,
   // Stack pointers
   input wire logic interrupt_stack_pointer_wr_i,
   input wire logic [WORD_W-1:0] sp_wr_data_i,
   input wire logic [WORD_W-1:0] user_stack_pointer_o,
   input wire logic [WORD_W-1:0] interrupt_stack_pointer_o,
   input wire logic [WORD_W-1:0] active_sp_o,
   // Flag word
   input wire logic cpu_flag_word_wr_i,
   input wire logic [FLAG_W-1:0] cpu_flag_word_data_i,
   input wire logic [FLAG_W-1:0] cpu_flag_word_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   fb_write_a:
      assert property (frame_base_wr_i |=> frame_base_o == $past(base_wr_data_i))
      else $error("frame base write lost");
   sb_write_a:
      assert property (static_base_wr_i |=> static_base_o == $past(base_wr_data_i))
      else $error("static base write lost");
   fb_hold_a:
      assert property (!frame_base_wr_i |=> $stable(frame_base_o))
      else $error("frame base moved without a write");
   isp_write_a:
      assert property (interrupt_stack_pointer_wr_i |=>
         interrupt_stack_pointer_o == $past(sp_wr_data_i))
      else $error("interrupt stack pointer write lost");
   sp_user_a:
      assert property (!cpu_flag_word_o[`CRF_FLG_STACK] |-> active_sp_o == user_stack_pointer_o)
      else $error("active pointer is not the user one");
   sp_irq_a:
      assert property (cpu_flag_word_o[`CRF_FLG_STACK] |->
         active_sp_o == interrupt_stack_pointer_o)
      else $error("active pointer is not the interrupt one");
   flag_write_a:
      assert property (cpu_flag_word_wr_i |=> cpu_flag_word_o == $past(cpu_flag_word_data_i))
      else $error("flag word write lost");
   flag_hold_a:
      assert property (!cpu_flag_word_wr_i |=> $stable(cpu_flag_word_o))
      else $error("flag word moved without a write");
   // Main scenarios reached
   cover property (frame_base_wr_i ##1 static_base_wr_i);
   cover property (cpu_flag_word_wr_i ##1 cpu_flag_word_o[`CRF_FLG_STACK]);
   cover property (interrupt_stack_pointer_wr_i);
endmodule

// ==== testbench/crf_exec_model.sv ====
// Model of the execution logic that reads and writes the register file.
// Assumes the bench calls its tasks; requests change just after rising edges.
`timescale 1ns/1ps
module crf_exec_model (
   // Clock and read data
   input wire logic ref_clk_i,
   input wire logic [31:0] gpr_rd_data_o,
   // Banked access
   output wire logic gpr_wr_en_i,
   output wire logic [3:0] gpr_wr_sel_i,
   output wire logic [31:0] gpr_wr_data_i,
   output wire logic [3:0] gpr_rd_sel_i,
   // Dedicated register strobes and data
   output wire logic frame_base_wr_i,
   output wire logic static_base_wr_i,
   output wire logic [15:0] base_wr_data_i,
   output wire logic vector_table_base_wr_i,
   output wire logic [19:0] vector_table_base_data_i,
   output wire logic next_instr_pointer_wr_i,
   output wire logic [19:0] next_instr_pointer_data_i,
   output wire logic user_stack_pointer_wr_i,
   output wire logic interrupt_stack_pointer_wr_i,
   output wire logic active_sp_wr_i,
   output wire logic [15:0] sp_wr_data_i,
   output wire logic cpu_flag_word_wr_i,
   output wire logic [10:0] cpu_flag_word_data_i
);
   logic en = 1'b0; // Banked write strobe
   logic [3:0] ws = 4'h0;
   logic [3:0] rs = 4'h0;
   logic [31:0] wd = 32'h0;
   logic [7:0] stb = 8'h00; // One strobe per dedicated register
   logic [31:0] pd = 32'h0;
   assign gpr_wr_en_i = en;
   assign gpr_wr_sel_i = ws;
   assign gpr_wr_data_i = wd;
   assign gpr_rd_sel_i = rs;
   assign {cpu_flag_word_wr_i, active_sp_wr_i, interrupt_stack_pointer_wr_i,
      user_stack_pointer_wr_i, next_instr_pointer_wr_i, vector_table_base_wr_i,
      static_base_wr_i, frame_base_wr_i} = stb;
   assign base_wr_data_i = pd[15:0];
   assign sp_wr_data_i = pd[15:0];
   assign vector_table_base_data_i = pd[19:0];
   assign next_instr_pointer_data_i = pd[19:0];
   assign cpu_flag_word_data_i = pd[10:0];
   // One-cycle write; the task's leading edge keeps the idle cycle after a pair
   task automatic put_gpr(input logic [3:0] sel, input logic [31:0] d);
      @(posedge ref_clk_i);
      en <= 1'b1;
      ws <= sel;
      wd <= d;
      @(posedge ref_clk_i);
      en <= 1'b0;
   endtask
   // Read data stands in the cycle after the select is sampled
   task automatic get_gpr(input logic [3:0] sel, output logic [31:0] d);
      @(posedge ref_clk_i);
      rs <= sel;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      d = gpr_rd_data_o;
   endtask
   // Pulse one dedicated strobe, then wait until the output settles
   task automatic put_ded(input int k, input logic [31:0] d);
      @(posedge ref_clk_i);
      stb <= 8'h01 << k;
      pd <= d;
      @(posedge ref_clk_i);
      stb <= 8'h00;
      @(negedge ref_clk_i);
   endtask
endmodule

// ==== testbench/crf_core_regs_tb.sv ====
// Self-checking bench for the core register file, driven through the model.
// Assumes a 25 MHz clock and a reset held for five cycles.
`timescale 1ns/1ps
module crf_core_regs_tb;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   wire gpr_wr_en_i, frame_base_wr_i, static_base_wr_i, vector_table_base_wr_i;
   wire next_instr_pointer_wr_i, user_stack_pointer_wr_i, interrupt_stack_pointer_wr_i;
   wire active_sp_wr_i, cpu_flag_word_wr_i;
   wire [3:0] gpr_wr_sel_i, gpr_rd_sel_i;
   wire [31:0] gpr_wr_data_i, gpr_rd_data_o;
   wire [15:0] base_wr_data_i, frame_base_o, static_base_o, sp_wr_data_i;
   wire [15:0] user_stack_pointer_o, interrupt_stack_pointer_o, active_sp_o;
   wire [19:0] vector_table_base_data_i, vector_table_base_o;
   wire [19:0] next_instr_pointer_data_i, next_instr_pointer_o;
   wire [10:0] cpu_flag_word_data_i, cpu_flag_word_o;
   int bad_count = 0;
   int check_count = 0;
   logic [31:0] r;
   logic [31:0] d;
   crf_core_regs dut (.ref_clk_i, .rst_n_i, .gpr_wr_en_i, .gpr_wr_sel_i, .gpr_wr_data_i,
      .gpr_rd_sel_i, .gpr_rd_data_o, .frame_base_wr_i, .static_base_wr_i, .base_wr_data_i,
      .frame_base_o, .static_base_o, .vector_table_base_wr_i, .vector_table_base_data_i,
      .vector_table_base_o, .next_instr_pointer_wr_i, .next_instr_pointer_data_i,
      .next_instr_pointer_o, .user_stack_pointer_wr_i, .interrupt_stack_pointer_wr_i,
      .active_sp_wr_i, .sp_wr_data_i, .user_stack_pointer_o, .interrupt_stack_pointer_o,
      .active_sp_o, .cpu_flag_word_wr_i, .cpu_flag_word_data_i, .cpu_flag_word_o);
   crf_exec_model exe (.ref_clk_i, .gpr_rd_data_o, .gpr_wr_en_i, .gpr_wr_sel_i,
      .gpr_wr_data_i, .gpr_rd_sel_i, .frame_base_wr_i, .static_base_wr_i, .base_wr_data_i,
      .vector_table_base_wr_i, .vector_table_base_data_i, .next_instr_pointer_wr_i,
      .next_instr_pointer_data_i, .user_stack_pointer_wr_i, .interrupt_stack_pointer_wr_i,
      .active_sp_wr_i, .sp_wr_data_i, .cpu_flag_word_wr_i, .cpu_flag_word_data_i);
   always #20 ref_clk_i = ~ref_clk_i;
   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Six banked words; upper half of the write data must be dropped
   task automatic s_words;
      for (int i = 0; i < 6; i++) exe.put_gpr(i[3:0], 32'hffff_8100 + i);
      for (int i = 0; i < 6; i++) begin
         exe.get_gpr(i[3:0], r);
         chk(r, 32'h0000_8100 + i);
      end
   endtask
   // Byte halves merge into the word
   task automatic s_bytes;
      exe.put_gpr(4'h0, 32'h0000_1234);
      exe.put_gpr(4'h7, 32'h0000_00ab);
      exe.put_gpr(4'h1, 32'h0000_5678);
      exe.put_gpr(4'h8, 32'h0000_00cd);
      exe.get_gpr(4'h0, r);
      chk(r, 32'h0000_ab34);
      exe.get_gpr(4'h6, r);
      chk(r, 32'h0000_0034);
      exe.get_gpr(4'h1, r);
      chk(r, 32'h0000_56cd);
      exe.get_gpr(4'h9, r);
      chk(r, 32'h0000_0056);
   endtask
   // Pairs land in their two halves
   task automatic s_pairs;
      for (int i = 0; i < 3; i++) begin
         d = 32'h89ab_cdef + i * 32'h0101_0101;
         exe.put_gpr(4'ha + i, d);
         exe.get_gpr(4'ha + i, r);
         chk(r, d);
         exe.get_gpr((i == 2) ? 4'h5 : 4'h2 + i, r);
         chk(r, {16'h0, d[31:16]});
         exe.get_gpr((i == 2) ? 4'h4 : i, r);
         chk(r, {16'h0, d[15:0]});
      end
   endtask
   // Bank one is separate storage
   task automatic s_bank;
      exe.put_ded(7, 32'h0000_0010);
      exe.get_gpr(4'h4, r);
      chk(r, 32'h0);
      exe.put_gpr(4'h0, 32'h0000_4242);
      exe.get_gpr(4'h0, r);
      chk(r, 32'h0000_4242);
      exe.put_ded(7, 32'h0);
      exe.get_gpr(4'h0, r);
      chk(r, 32'h0000_cdef);
   endtask
   // Full-width dedicated registers
   task automatic s_ded;
      for (int k = 0; k < 4; k++) begin
         d = 32'hfffd_a5a5 + k;
         exe.put_ded(k, d);
         if (k == 0) chk(frame_base_o, d[15:0]);
         if (k == 1) chk(static_base_o, d[15:0]);
         if (k == 2) chk(vector_table_base_o, d[19:0]);
         if (k == 3) chk(next_instr_pointer_o, d[19:0]);
      end
   endtask
   // Stack select follows the flag bit
   task automatic s_stack;
      exe.put_ded(4, 32'h1111);
      exe.put_ded(5, 32'h2222);
      chk(active_sp_o, 32'h1111);
      exe.put_ded(7, 32'hffff_f7ef);
      chk(cpu_flag_word_o, 32'h7ef);
      chk(active_sp_o, 32'h2222);
      exe.put_ded(6, 32'h3333);
      chk(interrupt_stack_pointer_o, 32'h3333);
      chk(user_stack_pointer_o, 32'h1111);
      exe.put_ded(7, 32'h0);
      exe.put_ded(6, 32'h4444);
      chk(user_stack_pointer_o, 32'h4444);
      chk(interrupt_stack_pointer_o, 32'h3333);
   endtask
   initial begin
      repeat (5) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      s_words();
      s_bytes();
      s_pairs();
      s_bank();
      s_ded();
      s_stack();
      report_and_stop();
   end
   // Cut a hang short
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      bad_count++;
      report_and_stop();
   end
endmodule
bind crf_core_regs crf_core_regs_monitor #(.WORD_W(WORD_W), .FLAG_W(FLAG_W)) mon (
   .ref_clk_i, .rst_n_i, .frame_base_wr_i, .static_base_wr_i, .base_wr_data_i,
   .frame_base_o, .static_base_o, .interrupt_stack_pointer_wr_i, .sp_wr_data_i,
   .user_stack_pointer_o, .interrupt_stack_pointer_o, .active_sp_o,
   .cpu_flag_word_wr_i, .cpu_flag_word_data_i, .cpu_flag_word_o);
